// ===== hdl/mpls_label_action_map.svh
// constants for the label-handling action decoder: field codes, limits and reset values
// assumes inclusion by the package and the decoder files only
`ifndef MPLS_LABEL_ACTION_MAP_SVH
`define MPLS_LABEL_ACTION_MAP_SVH

`define SEL_KEEP 2'h3
`define MAX_LABEL_DEPTH 2'h2
`define LABEL_ENTRIES 3
`define FWD_NONE 4'h0
`define FWD_PW_TERM 4'h1
`define FWD_SWAP 4'h2
`define FWD_POP 4'h3
`define FWD_CONTROL_PDU_MODE 4'h4
`define PDU_RESERVED 3'h6
`define POS_KEEP 2'h0
`define TC_RESET 3'h0
`define TTL_RESET 8'h00

`endif

// ===== hdl/mpls_label_action_pkg.sv
// types shared by the label-handling action decoder
// assumes the map header sits beside it on the include path
package mpls_label_action_pkg;
    `include "mpls_label_action_map.svh"

    // one label stack entry as handed over by the parser
    typedef struct packed {
        logic [19:0] label;
        logic [2:0] tc;
        logic bos;
        logic [7:0] ttl;
    } lse_t;

    // label-handling part of the action word
    typedef struct packed {
        logic [1:0] tcSourceSelect;
        logic [1:0] ttlSourceSelect;
        logic [1:0] validLabelDepth;
        logic [3:0] forwardingType;
        logic [2:0] oamChannelType;
        logic [2:0] oamDetectSelect;
    } action_t;

    typedef enum logic [2:0] {
        FWD_ACT_NONE = 3'b000,
        FWD_ACT_PW = 3'b001,
        FWD_ACT_SWAP = 3'b010,
        FWD_ACT_POP = 3'b011,
        FWD_ACT_CTRL = 3'b100,
        FWD_ACT_BAD = 3'b111
    } fwd_action_t;

    // pdu position choice in control-pdu mode
    typedef enum logic [1:0] {
        POS_UNCHANGED = 2'b00,
        POS_ETH_PAYLOAD = 2'b01,
        POS_IP_PAYLOAD = 2'b10,
        POS_NON_NORMALIZED = 2'b11
    } pdu_pos_t;

    // decoded results for the frame rewriter
    typedef struct packed {
        fwd_action_t action;
        logic terminatePw;
        logic doSwap;
        logic doPop;
        logic [1:0] swapIndex;
        logic [1:0] popCount;
        logic [1:0] pwIndex;
        logic oamDetectAllowed;
        logic ctrlPdu;
        logic [2:0] headerPduKind;
        pdu_pos_t pduPosition;
        logic pduPositionUpdate;
        logic configError;
    } result_t;
endpackage

// ===== hdl/lse_field_pick.sv
// picks tc and ttl from one of the first label stack entries
// assumes entries are already stripped of skipped reserved labels
`timescale 1ns/10ps
module lse_field_pick (
    input wire mpls_label_action_pkg::lse_t [2:0] entries,
    input wire logic [1:0] labelCount,
    input wire logic [1:0] tcSelect,
    input wire logic [1:0] ttlSelect,
    input wire logic [2:0] tcIn,
    input wire logic [7:0] ttlIn,
    output logic [2:0] tcOut,
    output logic [7:0] ttlOut
);
    import mpls_label_action_pkg::*;

    logic [2:0] present;

    // entry k exists when the stack holds more than k entries
    genvar k;
    generate
        for (k = 0; k < `LABEL_ENTRIES; k++) begin : g_present
            assign present[k] = labelCount > 2'(k);
        end
    endgenerate

    // code 3 or a missing entry keeps the incoming value
    always_comb begin
        tcOut = tcIn;
        ttlOut = ttlIn;
        if (tcSelect != `SEL_KEEP && present[tcSelect]) begin
            tcOut = entries[tcSelect].tc;
        end
        if (ttlSelect != `SEL_KEEP && present[ttlSelect]) begin
            ttlOut = entries[ttlSelect].ttl;
        end
    end
endmodule

// ===== hdl/mpls_label_action_decode.sv
// decoder for the label-handling part of a classification action word
// assumes the lookup engine presents action and label stack with actValid,
// and the frame rewriter takes results one cycle later on resValid
// Summary of operation
// - tc selector 0..2 takes that entry's tc if present; 3 keeps tc
// - ttl selector 0..2 takes that entry's ttl if present; 3 keeps ttl
// - entry 0 is the outermost label, higher indices lie deeper
// - valid depth counts from 0 at the top, legal range 0 to 2
// - skipped reserved labels do not count toward the valid depth
// - depth means nothing, pw position, swap position or deepest pop
// - type 0 none, 1 pw termination, 2 swap, 3 pop
// - type 4 is control-pdu mode, oam type sets pdu kind directly
// - type none does no termination, swap or pop
// - swap replaces label at depth, pops all above it
// - swap detects no oam; reserved label or ttl expiry may redirect
// - control-pdu mode passes oam type as header pdu kind
// - control-pdu mode oam selector picks the pdu position
`timescale 1ns/10ps
module mpls_label_action_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic actValid,
    input wire mpls_label_action_pkg::action_t action,
    input wire mpls_label_action_pkg::lse_t [2:0] labelStack,
    input wire logic [1:0] labelCount,
    input wire logic [2:0] tcIn,
    input wire logic [7:0] ttlIn,
    input wire logic reservedLabelSeen,
    input wire logic ttlExpired,
    output logic resValid,
    output mpls_label_action_pkg::result_t result,
    output logic [2:0] tcOut,
    output logic [7:0] ttlOut,
    output logic cpuRedirect
);
    import mpls_label_action_pkg::*;

    logic resValid_q, resValid_d;
    result_t result_q, result_d;
    logic [2:0] tc_q, tc_d;
    logic [7:0] ttl_q, ttl_d;
    logic redirect_q, redirect_d;
    logic [2:0] pickTc;
    logic [7:0] pickTtl;
    logic depthOk;
    logic depthPresent;

    // label count already excludes skipped reserved labels upstream
    lse_field_pick u_pick (
        .entries(labelStack),
        .labelCount(labelCount),
        .tcSelect(action.tcSourceSelect),
        .ttlSelect(action.ttlSourceSelect),
        .tcIn(tcIn),
        .ttlIn(ttlIn),
        .tcOut(pickTc),
        .ttlOut(pickTtl)
    );

    // depth must be in range and name an entry the frame really carries
    always_comb begin
        depthOk = action.validLabelDepth <= `MAX_LABEL_DEPTH;
        depthPresent = action.validLabelDepth < labelCount;
    end

    // decode forwarding type and fill every result field
    always_comb begin
        result_d = '0;
        result_d.action = FWD_ACT_NONE;
        result_d.pduPosition = POS_UNCHANGED;
        redirect_d = 1'b0;
        resValid_d = actValid;
        tc_d = tc_q;
        ttl_d = ttl_q;
        if (actValid) begin
            tc_d = pickTc;
            ttl_d = pickTtl;
            unique case (action.forwardingType)
                `FWD_NONE: begin
                    // depth ignored, nothing stripped or swapped
                    result_d.action = FWD_ACT_NONE;
                    result_d.oamDetectAllowed = 1'b1;
                end
                `FWD_PW_TERM: begin
                    result_d.action = FWD_ACT_PW;
                    result_d.terminatePw = 1'b1;
                    result_d.pwIndex = action.validLabelDepth;
                    result_d.oamDetectAllowed = 1'b1;
                    // out-of-range oam type is flagged, not acted upon
                    result_d.configError = (action.oamChannelType > 3'h4)
                        || !depthOk || !depthPresent;
                end
                `FWD_SWAP: begin
                    result_d.action = FWD_ACT_SWAP;
                    result_d.doSwap = depthOk && depthPresent;
                    result_d.swapIndex = action.validLabelDepth;
                    // everything above the swap label is popped
                    result_d.popCount = action.validLabelDepth;
                    result_d.oamDetectAllowed = 1'b0;
                    redirect_d = reservedLabelSeen || ttlExpired;
                    result_d.configError = !depthOk || !depthPresent;
                end
                `FWD_POP: begin
                    result_d.action = FWD_ACT_POP;
                    result_d.doPop = depthOk && depthPresent;
                    // deepest popped position is inclusive, so count is +1
                    result_d.popCount =
                        2'(action.validLabelDepth + 2'h1);
                    result_d.oamDetectAllowed = 1'b1;
                    result_d.configError = !depthOk || !depthPresent ||
                        !(action.oamChannelType == 3'h0 ||
                          action.oamChannelType == 3'h5 ||
                          action.oamChannelType == 3'h6);
                end
                `FWD_CONTROL_PDU_MODE: begin
                    result_d.action = FWD_ACT_CTRL;
                    result_d.ctrlPdu = 1'b1;
                    // kind passes straight through, post-processing bypassed
                    result_d.headerPduKind = action.oamChannelType;
                    result_d.configError =
                        action.oamChannelType == `PDU_RESERVED;
                    // selector 4 and up have no position meaning
                    if (action.oamDetectSelect[2]) begin
                        result_d.pduPosition = POS_UNCHANGED;
                        result_d.configError = 1'b1;
                    end else begin
                        result_d.pduPosition =
                            pdu_pos_t'(action.oamDetectSelect[1:0]);
                    end
                    result_d.pduPositionUpdate =
                        result_d.pduPosition != POS_UNCHANGED;
                end
                default: begin
                    // undefined codes report the bad action and are flagged; nothing stripped, swapped or oam-enabled
                    result_d.action = FWD_ACT_BAD;
                    result_d.configError = 1'b1;
                end
            endcase
        end
    end

    // register all results; outputs come straight from flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resValid_q <= 1'b0;
            result_q <= '0;
            tc_q <= `TC_RESET;
            ttl_q <= `TTL_RESET;
            redirect_q <= 1'b0;
        end else begin
            resValid_q <= resValid_d;
            result_q <= result_d;
            tc_q <= tc_d;
            ttl_q <= ttl_d;
            redirect_q <= redirect_d;
        end
    end

    assign resValid = resValid_q;
    assign result = result_q;
    assign tcOut = tc_q;
    assign ttlOut = ttl_q;
    assign cpuRedirect = redirect_q;
endmodule

// ===== sim/mpls_label_action_chk.sv
// assertions on the ports of the label-handling action decoder
// assumes one clock, async active-low reset, answers one cycle on
`timescale 1ns/10ps
module mpls_label_action_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic actValid,
    input wire mpls_label_action_pkg::action_t action,
    input wire mpls_label_action_pkg::lse_t [2:0] labelStack,
    input wire logic [1:0] labelCount,
    input wire logic [2:0] tcIn,
    input wire logic [7:0] ttlIn,
    input wire logic resValid,
    input wire mpls_label_action_pkg::result_t result,
    input wire logic [2:0] tcOut,
    input wire logic [7:0] ttlOut
);
    import mpls_label_action_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a swap or pop whose depth names a present entry
    sequence reqDeep(logic [3:0] t);
        actValid && action.forwardingType == t
            && action.validLabelDepth < labelCount;
    endsequence
    answer_timing_a: assert property (actValid |=> resValid)
        else $error("no answer one cycle after a request");
    idle_quiet_a: assert property (!actValid |=> !resValid && result == '0)
        else $error("answer without a request");
    none_inert_a: assert property (actValid && action.forwardingType == 0
        |=> !result.doSwap && !result.doPop && !result.terminatePw)
        else $error("type none changed the label stack");
    swap_depth_a: assert property (reqDeep(4'h2) |=> result.doSwap
        && result.swapIndex == $past(action.validLabelDepth)
        && result.popCount == $past(action.validLabelDepth))
        else $error("swap position or pop count wrong");
    pop_depth_a: assert property (reqDeep(4'h3) |=> result.doPop
        && result.popCount == $past(action.validLabelDepth) + 2'h1)
        else $error("pop count wrong");
    swap_no_oam_a: assert property (resValid && result.doSwap
        |-> !result.oamDetectAllowed)
        else $error("oam detection allowed in swap");
    ctrl_kind_a: assert property (actValid && action.forwardingType == 4
        |=> result.ctrlPdu
        && result.headerPduKind == $past(action.oamChannelType))
        else $error("control pdu kind not passed on");
    tc_keep_a: assert property (actValid && action.tcSourceSelect == 2'h3
        |=> tcOut == $past(tcIn))
        else $error("tc changed with keep selector");
    ttl_pick_a: assert property (actValid && action.ttlSourceSelect < 2'h3
        && action.ttlSourceSelect < labelCount |=> ttlOut
        == $past(labelStack[action.ttlSourceSelect].ttl))
        else $error("ttl not taken from selected entry");
    out_hold_a: assert property (!actValid |=> $stable(tcOut)
        && $stable(ttlOut))
        else $error("classified values moved without a request");
endmodule
bind mpls_label_action_decode mpls_label_action_chk chk (.*);

// ===== sim/lookup_engine_model.sv
// random action words and label stacks as the lookup engine hands them
// assumes reserved labels were already stripped by the parser
`timescale 1ns/10ps
module lookup_engine_model (
    input wire logic clk,
    input wire logic run,
    output logic actValid,
    output mpls_label_action_pkg::action_t action,
    output mpls_label_action_pkg::lse_t [2:0] labelStack,
    output logic [1:0] labelCount,
    output logic [2:0] tcIn,
    output logic [7:0] ttlIn,
    output logic reservedLabelSeen,
    output logic ttlExpired
);
    import mpls_label_action_pkg::*;
    integer seed = 32'hBE668D47;
    // offset, next-type and normalization fields live outside this block,
    // so the engine is trusted to set them per type
    // likewise for swap and pop set-ups
    // oam codes stay random so illegal set-ups are exercised too,
    // both the legal pw and pop codes and the others
    always @(posedge clk) begin
        actValid <= run && ($random(seed) % 4 != 0);
        action <= $random(seed);
        action.validLabelDepth <= $unsigned($random(seed)) % 3;
        for (int i = 0; i < 3; i++) begin
            labelStack[i] <= $random(seed);
            labelStack[i].label[4] <= 1'b1;
        end
        labelCount <= $random(seed); // entry 0 outermost
        tcIn <= $random(seed);
        ttlIn <= $random(seed);
        reservedLabelSeen <= $random(seed);
        ttlExpired <= $random(seed);
    end
endmodule

// ===== sim/mpls_label_action_decode_bench.sv
// self-checking bench for the label-handling action decoder
// assumes the engine model drives inputs and the bound checker watches
`timescale 1ns/10ps
module mpls_label_action_decode_bench;
    import mpls_label_action_pkg::*;
    typedef struct packed {
        action_t a;
        lse_t [2:0] s;
        logic [1:0] n;
        logic [2:0] tc;
        logic [7:0] ttl;
        logic r;
        logic x;
    } req_t;
    logic clk = 0, rst_n = 0, run = 0, actValid, reservedLabelSeen;
    logic ttlExpired, resValid, cpuRedirect;
    action_t action;
    lse_t [2:0] labelStack;
    logic [1:0] labelCount;
    logic [2:0] tcIn, tcOut;
    logic [7:0] ttlIn, ttlOut;
    result_t result;
    req_t q[$];
    req_t r;
    int n_errors = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    lookup_engine_model eng (.clk(clk), .run(run), .actValid(actValid),
        .action(action), .labelStack(labelStack), .labelCount(labelCount),
        .tcIn(tcIn), .ttlIn(ttlIn), .reservedLabelSeen(reservedLabelSeen),
        .ttlExpired(ttlExpired));
    mpls_label_action_decode dut (.clk(clk), .rst_n(rst_n),
        .actValid(actValid), .action(action), .labelStack(labelStack),
        .labelCount(labelCount), .tcIn(tcIn), .ttlIn(ttlIn),
        .reservedLabelSeen(reservedLabelSeen), .ttlExpired(ttlExpired),
        .resValid(resValid), .result(result), .tcOut(tcOut),
        .ttlOut(ttlOut), .cpuRedirect(cpuRedirect));
    task check(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reference model: pop the request answered now, then queue this one
    always @(posedge clk) begin
        logic [3:0] t;
        logic [2:0] o, s;
        logic [1:0] d, pos;
        logic ok, err;
        if (rst_n && resValid) begin
            if (q.size() == 0) check("answer", 1, 0);
            else begin
                r = q.pop_front();
                t = r.a.forwardingType;
                d = r.a.validLabelDepth;
                o = r.a.oamChannelType;
                s = r.a.oamDetectSelect;
                ok = d < r.n;
                pos = s > 3 ? 2'h0 : s[1:0];
                // pw, swap and pop must name a present entry at the depth
                err = t > 4 || (t == 1 && o > 4) || (t == 4 && (o == 6
                    || s > 3)) || (t == 3 && !(o inside {0, 5, 6}))
                    || ((t == 1 || t == 2 || t == 3) && !ok);
                check("action", result.action, t < 5 ? t : 7);
                check("swap", result.doSwap, t == 2 && ok);
                check("pop", result.doPop, t == 3 && ok);
                if (t == 2 && ok) check("swapIdx", result.swapIndex, d);
                if (t == 3 && ok) check("popCnt", result.popCount, d + 1);
                check("term", result.terminatePw && t != 1, 0);
                check("cfgErr", result.configError, err);
                if (t < 4) check("oam", result.oamDetectAllowed, t != 2);
                if (t == 4) check("pos", result.pduPosition, pos);
                if (t == 4) check("upd", result.pduPositionUpdate, pos != 0);
                if (t == 4 && o != 6) check("kind", result.headerPduKind, o);
                if (t != 2 || ok) check("cpu", cpuRedirect, t == 2 && (r.r || r.x));
                s = r.a.tcSourceSelect;
                check("tc", tcOut, s < 3 && s < r.n ? r.s[s].tc : r.tc);
                s = r.a.ttlSourceSelect;
                check("ttl", ttlOut, s < 3 && s < r.n ? r.s[s].ttl : r.ttl);
            end
        end
        if (rst_n && actValid)
            q.push_back({action, labelStack, labelCount, tcIn, ttlIn,
                reservedLabelSeen, ttlExpired});
    end
    // main sequence: reset, random traffic, drain, verdict
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        run <= 1;
        repeat (3000) @(posedge clk);
        run <= 0;
        repeat (4) @(posedge clk);
        check("drained", q.size(), 0);
        test_done;
    end
    // watchdog well past the 3020 cycles the run needs
    initial begin
        #40000;
        n_errors++;
        test_done;
    end
endmodule
